/* File: rtl/irq_vector_regs.svh */
// Purpose: constants for the interrupt vector and priority map
// Assumes: vectors are 24-bit program addresses
// Notes:   source index equals priority level
`ifndef IRQ_VECTOR_REGS_SVH
`define IRQ_VECTOR_REGS_SVH

`define IRQ_NUM_SOURCES   25
`define IRQ_VEC_RESET     24'h008000
`define IRQ_VEC_TRAP      24'h008004
`define IRQ_VEC_BASE      24'h008008
`define IRQ_VEC_STEP      24'h000004
// wake-capable sources: 1,3..7,8,10,19
`define IRQ_WAKE_MASK     25'h00805FA
`define IRQ_PRIO_IDLE     5'h1F

`endif

/* File: rtl/irq_vector_pkg.sv */
// Purpose: types for the interrupt vector and priority map
// Assumes: nothing
// Notes:   kinds of vector fetch offered to the core
package irq_vector_pkg;
  typedef enum logic [1:0] {
    VEC_NONE  = 2'b00,
    VEC_RESET = 2'b01,
    VEC_TRAP  = 2'b10,
    VEC_IRQ   = 2'b11
  } vec_kind_t;
endpackage

/* File: rtl/interrupt_vector_priority_map.sv */
// Purpose: maps reset, trap and 25 sources to vectors and wakeup
// Assumes: requests are levels synchronous to clk
// Notes:   one cycle from request to vector
//
// Contract
// - reset vector 0x008000, reset wakes from halt
// - trap vector 0x008004, no priority, no wakeup
// - top level external irq: priority 0, 0x008008
// - auto wakeup unit: priority 1, 0x00800C, wakes
// - clock controller: priority 2, 0x008010, no wake
// - ports A to E: priorities 3..7, wake
// - CAN receive: priority 8, 0x008028, wakes
// - CAN transmit/error/status: priority 9, no wake
// - SPI end of transfer: priority 10, wakes
// - timer one update: priority 11, no wake
// - timer one capture: priority 12, no wake
// - timer two: priorities 13 and 14, no wake
// - timer three: priorities 15 and 16, no wake
// - serial port: priorities 17 and 18, no wake
// - I2C: priority 19, 0x008054, wakes
// - lin capable port: priorities 20, 21, no wake
// - ADC end of conversion: priority 22, no wake
// - timer four update: priority 23, no wake
// - data EEPROM: priority 24, 0x008068
`include "irq_vector_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module interrupt_vector_priority_map #(
  parameter int NSRC = `IRQ_NUM_SOURCES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // requests, bit index is the priority level
  input  wire logic [NSRC-1:0]   irqReq,
  input  wire logic [NSRC-1:0]   irqEnable,
  input  wire logic              trapReq,
  input  wire logic              halted,
  // to the core
  output logic                   vecValid,
  output logic [23:0]            vecAddr,
  output irq_vector_pkg::vec_kind_t vecKind,
  output logic [4:0]             vecPrio,
  output logic                   wakeup
);

  ////////////////////////////////////////////////////////////////////////
  logic rstSync1_q;
  logic rstSync2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] vecOf(input logic [4:0] prio);
    vecOf = `IRQ_VEC_BASE + (24'(prio) << 2);
  endfunction

  localparam logic [NSRC-1:0] WAKE = NSRC'(`IRQ_WAKE_MASK);

  logic [NSRC-1:0] pend;
  logic            anyPend;
  logic [4:0]      winner;
  logic            resetPend_q;
  logic            resetPend_d;
  logic            vecValid_d;
  logic [23:0]     vecAddr_d;
  irq_vector_pkg::vec_kind_t vecKind_d;
  logic [4:0]      vecPrio_d;
  logic            wakeup_d;

  assign pend    = irqReq & irqEnable;
  assign anyPend = |pend;

  // fixed priority: lowest index wins
  always_comb begin
    winner = `IRQ_PRIO_IDLE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        winner = 5'(i);
      end
    end
  end

  // reset vector is offered once after reset release
  always_comb begin
    resetPend_d = 1'b0;
    vecValid_d  = 1'b1;
    vecAddr_d   = 24'h000000;
    vecKind_d   = irq_vector_pkg::VEC_NONE;
    vecPrio_d   = `IRQ_PRIO_IDLE;
    wakeup_d    = 1'b0;
    if (resetPend_q) begin
      vecAddr_d = `IRQ_VEC_RESET;
      vecKind_d = irq_vector_pkg::VEC_RESET;
      wakeup_d  = halted;
    end else if (trapReq) begin
      vecAddr_d = `IRQ_VEC_TRAP;
      vecKind_d = irq_vector_pkg::VEC_TRAP;
    end else if (anyPend) begin
      vecAddr_d = vecOf(winner);
      vecKind_d = irq_vector_pkg::VEC_IRQ;
      vecPrio_d = winner;
    end else begin
      vecValid_d = 1'b0;
    end
    // wake test ignores arbitration: any wake source counts
    if (halted && |(pend & WAKE)) begin
      wakeup_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstSync2_q) begin
    if (!rstSync2_q) begin
      resetPend_q <= 1'b1;
      vecValid    <= 1'b0;
      vecAddr     <= 24'h000000;
      vecKind     <= irq_vector_pkg::VEC_NONE;
      vecPrio     <= `IRQ_PRIO_IDLE;
      wakeup      <= 1'b0;
    end else begin
      resetPend_q <= resetPend_d;
      vecValid    <= vecValid_d;
      vecAddr     <= vecAddr_d;
      vecKind     <= vecKind_d;
      vecPrio     <= vecPrio_d;
      wakeup      <= wakeup_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset vector shows for exactly one cycle, then gives way
  sequence s_resetOffer;
    vecValid && vecKind == irq_vector_pkg::VEC_RESET;
  endsequence

  sequence s_resetGone;
    vecKind != irq_vector_pkg::VEC_RESET;
  endsequence

  property p_resetVec;
    @(posedge clk) disable iff (!rstSync2_q)
    resetPend_q |=> s_resetOffer ##1 s_resetGone;
  endproperty
  a_resetVec: assert property (p_resetVec)
    else $error("reset vector not offered once");

  property p_firstVec;
    @(posedge clk) disable iff (!rstSync2_q)
    resetPend_q |=> vecAddr == `IRQ_VEC_RESET && vecValid;
  endproperty
  a_firstVec: assert property (p_firstVec)
    else $error("reset vector not offered");

  property p_trapVec;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && trapReq |=> vecAddr == 24'h008004
      && vecKind == irq_vector_pkg::VEC_TRAP && vecPrio == 5'h1F;
  endproperty
  a_trapVec: assert property (p_trapVec)
    else $error("trap vector wrong");

  property p_topLevelVec;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && !trapReq && pend[0] |=> vecAddr == 24'h008008;
  endproperty
  a_topLevelVec: assert property (p_topLevelVec)
    else $error("top level vector wrong");

  property p_autoWakeVec;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && !trapReq && pend[1:0] == 2'b10
      |=> vecAddr == 24'h00800C && vecPrio == 5'h01;
  endproperty
  a_autoWakeVec: assert property (p_autoWakeVec)
    else $error("auto wakeup vector wrong");

  property p_eeprom;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && !trapReq && pend == (NSRC'(1) << 24)
      |=> vecAddr == 24'h008068 && vecPrio == 5'h18;
  endproperty
  a_eeprom: assert property (p_eeprom)
    else $error("eeprom vector wrong");

  property p_clkNoWake;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && pend == (NSRC'(1) << 2) |=> !wakeup;
  endproperty
  a_clkNoWake: assert property (p_clkNoWake)
    else $error("clock controller woke device");

  property p_i2cWake;
    @(posedge clk) disable iff (!rstSync2_q)
    halted && pend[19] |=> wakeup;
  endproperty
  a_i2cWake: assert property (p_i2cWake)
    else $error("i2c did not wake");

  property p_lowestWins;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && !trapReq && pend[3] && pend[8]
      |=> vecPrio <= 5'h03;
  endproperty
  a_lowestWins: assert property (p_lowestWins)
    else $error("lower priority served first");

  // one source alone pending, no reset vector or trap in the way
  sequence s_alone(int k);
    !resetPend_q && !trapReq && pend == (NSRC'(1) << k);
  endsequence

  property p_clkVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(2) |=> vecAddr == 24'h008010 && vecPrio == 5'h02;
  endproperty
  a_clkVec: assert property (p_clkVec)
    else $error("clock controller vector wrong");

  property p_portAVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(3) |=> vecAddr == 24'h008014 && vecPrio == 5'h03;
  endproperty
  a_portAVec: assert property (p_portAVec)
    else $error("port A vector wrong");

  property p_portWake;
    @(posedge clk) disable iff (!rstSync2_q)
    halted && pend[5] |=> wakeup;
  endproperty
  a_portWake: assert property (p_portWake)
    else $error("port interrupt did not wake");

  property p_canRxVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(8) |=> vecAddr == 24'h008028 && wakeup == $past(halted);
  endproperty
  a_canRxVec: assert property (p_canRxVec)
    else $error("CAN receive vector or wake wrong");

  property p_canTxVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(9) |=> vecAddr == 24'h00802C && !wakeup;
  endproperty
  a_canTxVec: assert property (p_canTxVec)
    else $error("CAN transmit vector or wake wrong");

  property p_spiVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(10) |=> vecAddr == 24'h008030 && wakeup == $past(halted);
  endproperty
  a_spiVec: assert property (p_spiVec)
    else $error("SPI vector or wake wrong");

  property p_tmr1UpdVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(11) |=> vecAddr == 24'h008034 && !wakeup;
  endproperty
  a_tmr1UpdVec: assert property (p_tmr1UpdVec)
    else $error("timer one update vector wrong");

  property p_tmr1CapVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(12) |=> vecAddr == 24'h008038 && !wakeup;
  endproperty
  a_tmr1CapVec: assert property (p_tmr1CapVec)
    else $error("timer one capture vector wrong");

  property p_tmr2CapVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(14) |=> vecAddr == 24'h008040 && !wakeup;
  endproperty
  a_tmr2CapVec: assert property (p_tmr2CapVec)
    else $error("timer two capture vector wrong");

  property p_tmr3CapVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(16) |=> vecAddr == 24'h008048 && !wakeup;
  endproperty
  a_tmr3CapVec: assert property (p_tmr3CapVec)
    else $error("timer three capture vector wrong");

  property p_serRxVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(18) |=> vecAddr == 24'h008050 && !wakeup;
  endproperty
  a_serRxVec: assert property (p_serRxVec)
    else $error("serial receive vector wrong");

  property p_linRxVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(21) |=> vecAddr == 24'h00805C && !wakeup;
  endproperty
  a_linRxVec: assert property (p_linRxVec)
    else $error("lin port receive vector wrong");

  property p_adcVec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(22) |=> vecAddr == 24'h008060 && !wakeup;
  endproperty
  a_adcVec: assert property (p_adcVec)
    else $error("ADC vector wrong");

  property p_tmr4Vec;
    @(posedge clk) disable iff (!rstSync2_q)
    s_alone(23) |=> vecAddr == 24'h008064 && !wakeup;
  endproperty
  a_tmr4Vec: assert property (p_tmr4Vec)
    else $error("timer four vector wrong");

  // no wake-capable source pending means no wakeup, except while the reset vector is pending
  property p_noWake;
    @(posedge clk) disable iff (!rstSync2_q)
    !resetPend_q && (pend & WAKE) == '0 |=> !wakeup;
  endproperty
  a_noWake: assert property (p_noWake)
    else $error("wakeup without wake source");

endmodule

`default_nettype wire

/* File: testbench/irq_source_model.sv */
// Purpose: request sources and core acknowledge
// Assumes: core drops a source once its vector shows
// Notes:   ackEn low passes levels straight through
`timescale 1ns/100ps
`default_nettype none
module irq_source_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // stimulus
  input  wire logic [24:0] levelIn,
  input  wire logic        ackEn,
  // from the map
  input  wire logic        vecValid,
  input  wire logic [1:0]  vecKind,
  input  wire logic [4:0]  vecPrio,
  // to the map
  output logic [24:0]      irqReq
);
  logic [24:0] pend_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= '0;
    end else begin
      pend_q <= ackEn ? (pend_q | levelIn) : '0;
      // served source drops, no latching in the map
      if (ackEn && vecValid && vecKind == 2'h3 && vecPrio < 5'h19)
        pend_q[vecPrio] <= 1'b0;
    end
  end
  assign irqReq = ackEn ? pend_q : levelIn;
endmodule
`default_nettype wire

/* File: testbench/interrupt_vector_priority_map_tb_top.sv */
// Purpose: bench for the interrupt vector map
// Assumes: outputs answer one cycle after inputs
// Notes:   seeded random mixed with corners
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_priority_map_tb_top;
  logic        clk, rst_b, trapReq, halted, ackEn, vecValid, wakeup;
  logic [24:0] levelIn, irqEnable, irqReq;
  logic [23:0] vecAddr;
  logic [4:0]  vecPrio, last;
  int          errors, compares, cycles, n;
  irq_vector_pkg::vec_kind_t vecKind;
  localparam logic [24:0] WAKE = 25'h00805FA;
  interrupt_vector_priority_map i_dut (.clk(clk), .rst_b(rst_b),
    .irqReq(irqReq), .irqEnable(irqEnable), .trapReq(trapReq),
    .halted(halted), .vecValid(vecValid), .vecAddr(vecAddr),
    .vecKind(vecKind), .vecPrio(vecPrio), .wakeup(wakeup));
  irq_source_model i_src (.clk(clk), .rst_b(rst_b), .levelIn(levelIn),
    .ackEn(ackEn), .vecValid(vecValid), .vecKind(vecKind),
    .vecPrio(vecPrio), .irqReq(irqReq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [23:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [4:0] low(input logic [24:0] m);
    low = 5'h1F;
    for (int i = 24; i >= 0; i--)
      if (m[i]) low = 5'(i);
  endfunction
  task automatic drive(input logic [24:0] r, e, input logic t, h);
    logic [4:0] q;
    @(posedge clk);
    levelIn <= r;
    irqEnable <= e;
    trapReq <= t;
    halted <= h;
    @(posedge clk);
    #1;
    q = t ? 5'h1F : low(r & e);
    chk("kind", 24'(vecKind),
        t ? 24'h2 : (q != 5'h1F ? 24'h3 : 24'h0));
    chk("prio", 24'(vecPrio), 24'(q));
    chk("valid", 24'(vecValid), 24'(t || q != 5'h1F));
    if (t || q != 5'h1F)
      chk("addr", vecAddr,
          t ? 24'h008004 : 24'h008008 + 24'(q) * 24'h000004);
    chk("wake", 24'(wakeup), 24'(h && |(r & e & WAKE)));
  endtask
  initial begin
    rst_b = 1'b0;
    trapReq = 1'b0;
    halted = 1'b1;
    ackEn = 1'b0;
    levelIn = '0;
    irqEnable = '0;
    void'($urandom(12907));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    while (vecKind !== irq_vector_pkg::VEC_RESET && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("rstAddr", vecAddr, 24'h008000);
    chk("rstWake", 24'(wakeup), 24'h1);
    @(posedge clk);
    #1;
    chk("rstOnce", 24'(vecKind), 24'h0);
    $display("reset test done");
    for (int i = 0; i < 7; i++)
      drive(25'h1 << i, '1, 1'b0, 1'b1);
    for (int i = 7; i < 12; i++)
      drive(25'h1 << i, '1, 1'b0, 1'b1);
    for (int i = 12; i < 18; i++)
      drive(25'h1 << i, '1, 1'b0, 1'b1);
    for (int i = 18; i < 25; i++)
      drive(25'h1 << i, '1, 1'b0, 1'b1);
    drive('1, '1, 1'b1, 1'b0);
    drive(25'h4, '1, 1'b1, 1'b1);
    drive('1, '0, 1'b0, 1'b1);
    $display("corner test done");
    repeat (300)
      drive(25'($urandom), 25'($urandom | $urandom), ($urandom % 6) == 0,
            1'($urandom));
    $display("random test done");
    @(posedge clk);
    trapReq <= 1'b0;
    irqEnable <= '1;
    levelIn <= '0;
    // idle two cycles so no stale random vector gets acked
    repeat (2) @(posedge clk);
    ackEn <= 1'b1;
    levelIn <= 25'h1080A09;
    @(posedge clk);
    levelIn <= '0;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (vecKind === irq_vector_pkg::VEC_IRQ &&
          (n == 0 || vecPrio !== last)) begin
        chk("order", 24'(n == 0 || vecPrio > last), 24'h1);
        last = vecPrio;
        n++;
      end
    end
    // six sources raised (0, 3, 9, 11, 19, 24), each served once
    chk("served", 24'(n), 24'h6);
    $display("drain test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
